// File: logic/acc_pkg.sv
// Purpose: Constants and types for the analog comparator control block.
// Assumes: 32-bit Avalon-MM register bus, byte addresses.
// Notes:   Offsets are byte addresses of 32-bit words.
package acc_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [5:0] OFS_MASKED_IRQ = 6'h00;
    localparam logic [5:0] OFS_RAW_IRQ    = 6'h04;
    localparam logic [5:0] OFS_IRQ_EN     = 6'h08;
    localparam logic [5:0] OFS_REF_CTL    = 6'h10;
    localparam logic [5:0] OFS_OUT_STAT   = 6'h20;
    localparam logic [5:0] OFS_CTL        = 6'h24;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int BIT_IRQ        = 0;
    localparam int BIT_REF_EN     = 9;
    localparam int BIT_RANGE      = 8;
    localparam int TAP_LSB        = 0;
    localparam int TAP_W          = 4;
    localparam int BIT_OUT_VAL    = 1;
    localparam int BIT_TRIG_EN    = 11;
    localparam int SRC_LSB        = 9;
    localparam int BIT_TLVL       = 7;
    localparam int TRIG_SENSE_LSB = 5;
    localparam int BIT_ILVL       = 4;
    localparam int IRQ_SENSE_LSB  = 2;
    localparam int BIT_INV        = 1;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;

    // Sense encodings shared by interrupt and trigger paths
    localparam logic [1:0] SENSE_LEVEL = 2'h0;
    localparam logic [1:0] SENSE_FALL  = 2'h1;
    localparam logic [1:0] SENSE_RISE  = 2'h2;
    localparam logic [1:0] SENSE_BOTH  = 2'h3;

    // Positive input source encodings
    localparam logic [1:0] SRC_PIN_VALUE = 2'h0;
    localparam logic [1:0] SRC_POS_PIN   = 2'h1;
    localparam logic [1:0] SRC_INT_REF   = 2'h2;

    // Analog-side controls travel together
    typedef struct packed {
        logic       ladder_power;
        logic       ladder_range_sel;
        logic [3:0] ladder_tap;
        logic [1:0] pos_input_source;
    } acc_analog_ctl_type;

endpackage : acc_pkg

// File: logic/acc_top.sv
// Purpose: Register and event logic around one analog comparator.
// Assumes: Comparator output is asynchronous; Avalon-MM slave, 32-bit data.
// Notes:   waitrequest is low in every cycle; reads answer at the request edge.
//          The previous sample is kept after inversion, so flipping the
//          invert bit is itself seen as an edge by both sense paths.
//          Read data is combinational to keep the bus zero-wait; a flopped
//          read path would cost one wait state per access.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
module acc_top #(
    parameter int SYNC_STAGES = 2
) (
    input  wire logic                        core_clk_i,
    input  wire logic                        nrst_i,
    input  wire logic [5:0]                  avs_address_i,
    input  wire logic                        avs_read_i,
    input  wire logic                        avs_write_i,
    input  wire logic [31:0]                 avs_writedata_i,
    input  wire logic [3:0]                  avs_byteenable_i,
    output logic      [31:0]                 avs_readdata_o,
    output logic                             avs_waitrequest_o,
    input  wire logic                        cmp_out_i,
    output acc_pkg::acc_analog_ctl_type      analog_ctl_o,
    output logic                             adc_trigger_o,
    output logic                             irq_o
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    initial begin
        if (SYNC_STAGES < 2) begin
            $error("SYNC_STAGES must be at least 2");
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    logic        raw_irq_reg;
    logic        irq_en_reg;
    logic [31:0] ref_ctl_reg;
    logic [31:0] ctl_reg;
    logic [31:0] readdata_reg;
    logic        adc_trig_reg;
    logic [SYNC_STAGES-1:0] sync_reg;
    logic        prev_reg;
    logic        prev_valid_reg;

    // Sense decoding used twice: once for interrupt, once for trigger
    function automatic logic sense_hit(input logic [1:0] mode, input logic lvl,
                                       input logic cur, input logic prev, input logic pv);
        logic rise;
        logic fall;
        rise = pv & cur & ~prev;
        fall = pv & ~cur & prev;
        case (mode)
            acc_pkg::SENSE_LEVEL: sense_hit = (cur == lvl);
            acc_pkg::SENSE_FALL:  sense_hit = fall;
            acc_pkg::SENSE_RISE:  sense_hit = rise;
            default:              sense_hit = rise | fall;
        endcase
    endfunction : sense_hit

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    wire byte0_en  = avs_byteenable_i[0];
    wire byte1_en  = avs_byteenable_i[1];
    wire wr_mis    = avs_write_i && avs_address_i == acc_pkg::OFS_MASKED_IRQ;
    wire wr_en     = avs_write_i && avs_address_i == acc_pkg::OFS_IRQ_EN;
    wire wr_ref    = avs_write_i && avs_address_i == acc_pkg::OFS_REF_CTL;
    wire wr_ctl    = avs_write_i && avs_address_i == acc_pkg::OFS_CTL;
    // Byte mask for the low 16 bits, which hold every writable bit; upper lanes carry only reserved bits
    wire [31:0] be_mask = {16'h0000, {8{byte1_en}}, {8{byte0_en}}};
    // Writable bits only; everything else stays zero and reads zero
    localparam logic [31:0] REF_MASK = 32'h0000_030F;
    localparam logic [31:0] CTL_MASK = 32'h0000_0EFE;
    wire [31:0] ref_next = (ref_ctl_reg & ~(be_mask & REF_MASK))
                         | (avs_writedata_i & be_mask & REF_MASK);
    wire [31:0] ctl_next = (ctl_reg & ~(be_mask & CTL_MASK))
                         | (avs_writedata_i & be_mask & CTL_MASK);
    wire clr_irq = wr_mis && byte0_en && avs_writedata_i[acc_pkg::BIT_IRQ];

    // ****************************************************************
    // Comparator conditioning
    // ****************************************************************
    wire inv       = ctl_reg[acc_pkg::BIT_INV];
    wire cmp_sync  = sync_reg[SYNC_STAGES-1];
    wire cmp_cond  = cmp_sync ^ inv;
    // Previous sample already holds the inverted value
    wire prev_cond = prev_reg;
    wire [1:0] irq_sense  = ctl_reg[acc_pkg::IRQ_SENSE_LSB +: 2];
    wire [1:0] trig_sense = ctl_reg[acc_pkg::TRIG_SENSE_LSB +: 2];
    // Independent sense paths
    wire irq_hit  = sense_hit(irq_sense, ctl_reg[acc_pkg::BIT_ILVL], cmp_cond,
                              prev_cond, prev_valid_reg);
    wire trig_hit = sense_hit(trig_sense, ctl_reg[acc_pkg::BIT_TLVL], cmp_cond,
                              prev_cond, prev_valid_reg);
    wire masked   = raw_irq_reg & irq_en_reg;

    // ****************************************************************
    // Synchroniser and previous sample; first stage feeds only the second
    // ****************************************************************
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_reg       <= '0;
            prev_reg       <= 1'b0;
            prev_valid_reg <= 1'b0;
        end else begin
            sync_reg       <= {sync_reg[SYNC_STAGES-2:0], cmp_out_i};
            prev_reg       <= cmp_cond;
            prev_valid_reg <= 1'b1;
        end
    end

    // Raw flag: a set in the clear cycle wins so no event is lost
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            raw_irq_reg <= 1'b0;
        end else if (irq_hit) begin
            raw_irq_reg <= 1'b1;
        end else if (clr_irq) begin
            raw_irq_reg <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_en_reg  <= 1'b0;
            ref_ctl_reg <= acc_pkg::RESET_VAL;
            ctl_reg     <= acc_pkg::RESET_VAL;
        end else begin
            if (wr_en && byte0_en) begin
                irq_en_reg <= avs_writedata_i[acc_pkg::BIT_IRQ];
            end
            if (wr_ref) begin
                ref_ctl_reg <= ref_next;
            end
            if (wr_ctl) begin
                ctl_reg <= ctl_next;
            end
        end
    end

    // Trigger pulse from a flop; suppressed entirely when disabled
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            adc_trig_reg <= 1'b0;
        end else begin
            adc_trig_reg <= trig_hit & ctl_reg[acc_pkg::BIT_TRIG_EN];
        end
    end

    // ****************************************************************
    // Read path: combinational, zero-wait; unmapped reads return zero
    // ****************************************************************
    always_comb begin
        readdata_reg = 32'h0000_0000;
        case (avs_address_i)
            acc_pkg::OFS_MASKED_IRQ: readdata_reg[acc_pkg::BIT_IRQ] = masked;
            acc_pkg::OFS_RAW_IRQ:    readdata_reg[acc_pkg::BIT_IRQ] = raw_irq_reg;
            acc_pkg::OFS_IRQ_EN:     readdata_reg[acc_pkg::BIT_IRQ] = irq_en_reg;
            acc_pkg::OFS_REF_CTL:    readdata_reg = ref_ctl_reg;
            acc_pkg::OFS_OUT_STAT:   readdata_reg[acc_pkg::BIT_OUT_VAL] = cmp_cond;
            acc_pkg::OFS_CTL:        readdata_reg = ctl_reg;
            default:                 readdata_reg = 32'h0000_0000;
        endcase
    end

    assign avs_readdata_o    = avs_read_i ? readdata_reg : 32'h0000_0000;
    assign avs_waitrequest_o = 1'b0;
    assign irq_o             = masked;
    assign adc_trigger_o     = adc_trig_reg;
    assign analog_ctl_o.ladder_power     = ref_ctl_reg[acc_pkg::BIT_REF_EN];
    assign analog_ctl_o.ladder_range_sel = ref_ctl_reg[acc_pkg::BIT_RANGE];
    assign analog_ctl_o.ladder_tap       = ref_ctl_reg[acc_pkg::TAP_LSB +: acc_pkg::TAP_W];
    assign analog_ctl_o.pos_input_source = ctl_reg[acc_pkg::SRC_LSB +: 2];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_irq_gate;
        @(posedge core_clk_i) disable iff (!nrst_i) irq_o == (raw_irq_reg && irq_en_reg);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not raw AND enable");

    property p_clear;
        @(posedge core_clk_i) disable iff (!nrst_i) clr_irq && !irq_hit |=> !raw_irq_reg;
    endproperty
    a_clear: assert property (p_clear) else $error("W1C did not clear flag");

    property p_set_wins;
        @(posedge core_clk_i) disable iff (!nrst_i) irq_hit |=> raw_irq_reg;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("raw flag missed event");

    property p_sticky;
        @(posedge core_clk_i) disable iff (!nrst_i) raw_irq_reg && !clr_irq |=> raw_irq_reg;
    endproperty
    a_sticky: assert property (p_sticky) else $error("raw flag dropped");

    property p_trig_off;
        @(posedge core_clk_i) disable iff (!nrst_i)
            !ctl_reg[acc_pkg::BIT_TRIG_EN] |=> !adc_trigger_o;
    endproperty
    a_trig_off: assert property (p_trig_off) else $error("trigger not suppressed");

    property p_rise_trig;
        @(posedge core_clk_i) disable iff (!nrst_i)
            trig_sense == acc_pkg::SENSE_RISE && ctl_reg[acc_pkg::BIT_TRIG_EN] && prev_valid_reg
            && $rose(cmp_cond) && !$changed(ctl_reg) |=> adc_trigger_o;
    endproperty
    a_rise_trig: assert property (p_rise_trig) else $error("rising trigger missed");

    property p_level_irq;
        @(posedge core_clk_i) disable iff (!nrst_i)
            irq_sense == acc_pkg::SENSE_LEVEL && cmp_cond == ctl_reg[acc_pkg::BIT_ILVL] |=> raw_irq_reg;
    endproperty
    a_level_irq: assert property (p_level_irq) else $error("level irq missed");

    property p_edge_prev;
        @(posedge core_clk_i) disable iff (!nrst_i) prev_valid_reg |-> prev_reg == $past(cmp_cond);
    endproperty
    a_edge_prev: assert property (p_edge_prev) else $error("previous sample wrong");

    property p_invert;
        @(posedge core_clk_i) disable iff (!nrst_i)
            avs_read_i && avs_address_i == acc_pkg::OFS_OUT_STAT
            |-> avs_readdata_o[acc_pkg::BIT_OUT_VAL] == (cmp_sync ^ ctl_reg[acc_pkg::BIT_INV]);
    endproperty
    a_invert: assert property (p_invert) else $error("output status wrong");

    // Ladder controls follow a write in the next cycle
    property p_ladder_power;
        @(posedge core_clk_i) disable iff (!nrst_i)
            wr_ref && byte1_en |=> analog_ctl_o.ladder_power == $past(avs_writedata_i[acc_pkg::BIT_REF_EN]);
    endproperty
    a_ladder_power: assert property (p_ladder_power) else $error("ladder power wrong");

    property p_ladder_range;
        @(posedge core_clk_i) disable iff (!nrst_i)
            wr_ref && byte1_en |=> analog_ctl_o.ladder_range_sel == $past(avs_writedata_i[acc_pkg::BIT_RANGE]);
    endproperty
    a_ladder_range: assert property (p_ladder_range) else $error("ladder range wrong");

    property p_ladder_tap;
        @(posedge core_clk_i) disable iff (!nrst_i)
            wr_ref && byte0_en
            |=> analog_ctl_o.ladder_tap == $past(avs_writedata_i[acc_pkg::TAP_LSB +: acc_pkg::TAP_W]);
    endproperty
    a_ladder_tap: assert property (p_ladder_tap) else $error("ladder tap wrong");

    property p_source_sel;
        @(posedge core_clk_i) disable iff (!nrst_i)
            wr_ctl && byte1_en
            |=> analog_ctl_o.pos_input_source == $past(avs_writedata_i[acc_pkg::SRC_LSB +: 2]);
    endproperty
    a_source_sel: assert property (p_source_sel) else $error("input source wrong");

    // Trigger passes when enabled
    property p_trig_pass;
        @(posedge core_clk_i) disable iff (!nrst_i)
            trig_hit && ctl_reg[acc_pkg::BIT_TRIG_EN] |=> adc_trigger_o;
    endproperty
    a_trig_pass: assert property (p_trig_pass) else $error("enabled trigger lost");

    property p_level_trig;
        @(posedge core_clk_i) disable iff (!nrst_i)
            trig_sense == acc_pkg::SENSE_LEVEL && ctl_reg[acc_pkg::BIT_TRIG_EN]
            && cmp_cond == ctl_reg[acc_pkg::BIT_TLVL] |=> adc_trigger_o;
    endproperty
    a_level_trig: assert property (p_level_trig) else $error("level trigger missed");

    property p_fall_trig;
        @(posedge core_clk_i) disable iff (!nrst_i)
            trig_sense == acc_pkg::SENSE_FALL && ctl_reg[acc_pkg::BIT_TRIG_EN] && prev_valid_reg
            && $fell(cmp_cond) && !$changed(ctl_reg) |=> adc_trigger_o;
    endproperty
    a_fall_trig: assert property (p_fall_trig) else $error("falling trigger missed");

    property p_fall_irq;
        @(posedge core_clk_i) disable iff (!nrst_i)
            irq_sense == acc_pkg::SENSE_FALL && prev_valid_reg
            && $fell(cmp_cond) && !$changed(ctl_reg) |=> raw_irq_reg;
    endproperty
    a_fall_irq: assert property (p_fall_irq) else $error("falling irq missed");

    property p_low_irq;
        @(posedge core_clk_i) disable iff (!nrst_i)
            irq_sense == acc_pkg::SENSE_LEVEL && !ctl_reg[acc_pkg::BIT_ILVL] && !cmp_cond |=> raw_irq_reg;
    endproperty
    a_low_irq: assert property (p_low_irq) else $error("low level irq missed");

    // Reserved control bits never read back
    property p_ctl_reserved;
        @(posedge core_clk_i) disable iff (!nrst_i)
            avs_read_i && avs_address_i == acc_pkg::OFS_CTL |-> (avs_readdata_o & ~CTL_MASK) == 32'h0000_0000;
    endproperty
    a_ctl_reserved: assert property (p_ctl_reserved) else $error("reserved bits set");

    property p_masked_read;
        @(posedge core_clk_i) disable iff (!nrst_i)
            avs_read_i && avs_address_i == acc_pkg::OFS_MASKED_IRQ
            |-> avs_readdata_o[acc_pkg::BIT_IRQ] == (raw_irq_reg && irq_en_reg);
    endproperty
    a_masked_read: assert property (p_masked_read) else $error("masked status wrong");

    property p_irq_off;
        @(posedge core_clk_i) disable iff (!nrst_i) !irq_en_reg |-> !irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");

endmodule : acc_top

// File: testbench/acc_cmp_model.sv
// Purpose: Behavioural comparator core and ADC event input on the block's far side.
// Assumes: The bench commands on which side of the reference the test voltage sits.
// Notes:   A reserved source gives an undefined output, so the model toggles it.
`timescale 1ns/10ps
module acc_cmp_model (
    input  wire logic                        clk_i,
    input  wire acc_pkg::acc_analog_ctl_type ctl_i,
    input  wire logic                        above_i,
    input  wire logic                        trig_i,
    output logic                             cmp_out_o,
    output int                               trig_cnt_o
);
    // ****************************************
    // Comparator output and ADC event counter
    // ****************************************
    // Output moves just after an edge, like any asynchronous level would
    always_ff @(posedge clk_i) begin
        if (ctl_i.pos_input_source == 2'h3) begin
            cmp_out_o <= !cmp_out_o; // No defined input, so no stable output
        end else begin
            cmp_out_o <= above_i;
        end
    end
    // Every cycle with the event high is one sample-sequence start
    initial trig_cnt_o = 0;
    always @(posedge clk_i) begin
        if (trig_i === 1'b1) begin
            trig_cnt_o <= trig_cnt_o + 1;
        end
    end
endmodule : acc_cmp_model

// File: testbench/testbench.sv
// Purpose: Self-checking bench for the comparator control block.
// Assumes: Zero-wait slave, but the master still waits for waitrequest low.
// Notes:   Expected read data is queued by the driver, checked by the monitor.
`timescale 1ns/10ps
module testbench;
    logic                        core_clk_i = 1'b0;
    logic                        nrst_i     = 1'b0;
    logic [5:0]                  avs_address_i = 6'h00;
    logic                        avs_read_i = 1'b0;
    logic                        avs_write_i = 1'b0;
    logic [31:0]                 avs_writedata_i = 32'h0;
    logic [3:0]                  avs_byteenable_i = 4'hF;
    logic [31:0]                 avs_readdata_o;
    logic                        avs_waitrequest_o, cmp_out, adc_trigger_o, irq_o;
    logic                        above = 1'b0;
    acc_pkg::acc_analog_ctl_type analog_ctl_o;
    int                          trig_cnt, base, num_errors = 0, n_tests = 0, seed = 32'h622E;
    logic [31:0]                 q[$];
    logic [31:0]                 d, ctl;
    logic [5:0]                  rst_addr [6] = '{6'h08, 6'h10, 6'h20, 6'h24, 6'h00, 6'h3C};
    acc_top u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .cmp_out_i(cmp_out), .analog_ctl_o(analog_ctl_o),
        .adc_trigger_o(adc_trigger_o), .irq_o(irq_o));
    acc_cmp_model u_cmp (.clk_i(core_clk_i), .ctl_i(analog_ctl_o), .above_i(above),
        .trig_i(adc_trigger_o), .cmp_out_o(cmp_out), .trig_cnt_o(trig_cnt));
    // ****************************************
    // Clock, checking and closing
    // ****************************************
    initial forever #4 core_clk_i = !core_clk_i;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    // Read data stands only at the accepting edge, so it is taken there
    always @(posedge core_clk_i) begin
        if (avs_read_i === 1'b1 && avs_waitrequest_o === 1'b0) begin
            check(avs_readdata_o, q.pop_front());
        end
    end
    // A hang anywhere ends the run as a failure
    initial begin
        repeat (20000) @(posedge core_clk_i);
        num_errors++;
        finish_test();
    end
    // ****************************************
    // Bus and stimulus tasks
    // ****************************************
    // The leading edge keeps two assignments of a strobe out of one step
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] dat);
        int i;
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_writedata_i <= dat;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        i = 0;
        do begin
            @(posedge core_clk_i);
            i++;
        end while (avs_waitrequest_o !== 1'b0 && i < 50);
        if (i >= 50) begin
            num_errors++;
            finish_test();
        end
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rd
    // Synchroniser plus flag takes three edges; six leaves margin
    task automatic set_cmp(input logic v);
        @(posedge core_clk_i);
        above <= v;
        repeat (6) @(posedge core_clk_i);
    endtask : set_cmp
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        foreach (rst_addr[i]) begin
            rd(rst_addr[i], 32'h0);
        end
        $display("test reset values done");
        repeat (4) begin
            d = $random(seed);
            bus(1'b1, acc_pkg::OFS_CTL, d);
            bus(1'b1, acc_pkg::OFS_REF_CTL, d);
            rd(acc_pkg::OFS_CTL, d & 32'h0000_0EFE);
            rd(acc_pkg::OFS_REF_CTL, d & 32'h0000_030F);
            check(32'(analog_ctl_o), 32'({d[9], d[8], d[3:0], d[10:9]}));
        end
        $display("test register fields done");
        bus(1'b1, acc_pkg::OFS_IRQ_EN, 32'h1);
        for (int m = 1; m <= 3; m++) begin
            ctl = 32'h800 | (m << 2) | (((m % 3) + 1) << 5);
            bus(1'b1, acc_pkg::OFS_CTL, ctl);
            set_cmp(1'b0);
            bus(1'b1, acc_pkg::OFS_MASKED_IRQ, 32'h1);
            base = trig_cnt;
            set_cmp(1'b1);
            check(32'(irq_o), 32'(m >= 2));
            rd(acc_pkg::OFS_RAW_IRQ, 32'(m >= 2));
            rd(acc_pkg::OFS_MASKED_IRQ, 32'(m >= 2));
            bus(1'b1, acc_pkg::OFS_MASKED_IRQ, 32'h1);
            set_cmp(1'b0);
            rd(acc_pkg::OFS_RAW_IRQ, 32'(m != 2));
            check(32'(trig_cnt - base), (m == 2) ? 32'h2 : 32'h1);
        end
        $display("test edge sense done");
        bus(1'b1, acc_pkg::OFS_CTL, 32'h10);
        bus(1'b1, acc_pkg::OFS_MASKED_IRQ, 32'h1);
        rd(acc_pkg::OFS_RAW_IRQ, 32'h0);
        set_cmp(1'b1);
        rd(acc_pkg::OFS_RAW_IRQ, 32'h1);
        rd(acc_pkg::OFS_OUT_STAT, 32'h2);
        bus(1'b1, acc_pkg::OFS_CTL, 32'h0A);
        set_cmp(1'b1);
        bus(1'b1, acc_pkg::OFS_MASKED_IRQ, 32'h1);
        rd(acc_pkg::OFS_RAW_IRQ, 32'h0);
        rd(acc_pkg::OFS_OUT_STAT, 32'h0);
        bus(1'b1, acc_pkg::OFS_IRQ_EN, 32'h0);
        bus(1'b1, acc_pkg::OFS_CTL, 32'h08);
        set_cmp(1'b1);
        check(32'(irq_o), 32'h0);
        rd(acc_pkg::OFS_MASKED_IRQ, 32'h0);
        rd(acc_pkg::OFS_RAW_IRQ, 32'h1);
        bus(1'b1, acc_pkg::OFS_MASKED_IRQ, 32'h0);
        rd(acc_pkg::OFS_RAW_IRQ, 32'h1);
        bus(1'b1, acc_pkg::OFS_IRQ_EN, 32'h1);
        rd(acc_pkg::OFS_MASKED_IRQ, 32'h1);
        check(32'(irq_o), 32'h1);
        bus(1'b1, acc_pkg::OFS_MASKED_IRQ, 32'h1);
        rd(acc_pkg::OFS_RAW_IRQ, 32'h0);
        $display("test level, invert and gating done");
        bus(1'b1, acc_pkg::OFS_CTL, 32'h60);
        base = trig_cnt;
        set_cmp(1'b0);
        set_cmp(1'b1);
        check(32'(trig_cnt - base), 32'h0);
        $display("test trigger suppression done");
        finish_test();
    end
endmodule : testbench
